// *** logic/ptrp_pkg.sv ***
// Shared constants, types and notes for the program-memory table-read port.
// Functional notes
// - Program memory holds 640 12-bit words; 260h-27Fh never reach the program, lower words do.
// - The pointer is {1AH[1:0], 19H, 18H}, highest nibble first, and 1AH bits 3 and 2 read zero.
// - A pointer in 260h-27Fh gets bit 1 of 1AH cleared by hardware and every other bit kept.
// - Reading 1CH returns bits 3 to 0 of the addressed program word.
// - Reading 1DH returns bits 7 to 4 of the addressed program word.
// - Reading 1EH returns bits 11 to 8 of the addressed program word.
// - Writing 05h to 1DH sends a clear pulse to the watchdog timer.
// - A plain load from 1CH, 1DH or 1EH takes two cycles and every other access takes one.
// - 32 SRAM nibbles sit at 20H-3FH, cells 00H-1FH, only when the page selector is zero.
// - 00H-1FH reach the common I/O and special registers whatever the page selector holds.
// - Single-bit set and clear act only on addresses 00H to 0FH.
// - Common I/O addresses take load, arithmetic, logic and read-modify-write accesses.
// - Read-modify-write accesses write their result back to the very address they read.
package ptrp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int PROM_WORDS  = 640;
    localparam int PROM_AW     = 10;
    localparam int PROM_DW     = 12;
    localparam int NIB         = 4;
    localparam int ADDR_W      = 6;
    localparam int PAGE_W      = 4;
    localparam int PTR_HI_W    = 2;
    localparam int HI_CLR_BIT  = 1;
    localparam int SRAM_WORDS  = 32;
    localparam int SRAM_AW     = 5;
    localparam int PROM_LD_CYC = 2;

    // ------------------------------------------------------------------
    // Addresses and values
    // ------------------------------------------------------------------
    localparam logic [PROM_AW-1:0] PROM_READ_LIMIT = 10'h260;
    localparam logic [PROM_AW-1:0] PROM_LAST       = 10'h27F;
    // Upper pointer bits shared by every word of the reserved block.
    localparam logic [4:0]         RSV_TAG         = PROM_READ_LIMIT[PROM_AW-1:5];
    localparam logic [ADDR_W-1:0]  BIT_LAST        = 6'h0F;
    localparam logic [ADDR_W-1:0]  CMN_LAST        = 6'h1F;
    localparam logic [ADDR_W-1:0]  OWN_FIRST       = 6'h18;
    localparam logic [ADDR_W-1:0]  OFS_PTR_LOW     = 6'h18;
    localparam logic [ADDR_W-1:0]  OFS_PTR_MID     = 6'h19;
    localparam logic [ADDR_W-1:0]  OFS_PTR_HIGH    = 6'h1A;
    localparam logic [ADDR_W-1:0]  OFS_DATA_LOW    = 6'h1C;
    localparam logic [ADDR_W-1:0]  OFS_DATA_MID    = 6'h1D;
    localparam logic [ADDR_W-1:0]  OFS_DATA_HIGH   = 6'h1E;
    localparam logic [PAGE_W-1:0]  SRAM_PAGE       = 4'h0;
    localparam logic [NIB-1:0]     WDT_KICK_VAL    = 4'h5;
    localparam logic [NIB-1:0]     PTR_RST         = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_LD_RD  = 3'h0,
        OP_ALU_RD = 3'h1,
        OP_WR     = 3'h2,
        OP_RMW_RD = 3'h3,
        OP_WB     = 3'h4,
        OP_BSET   = 3'h5,
        OP_BCLR   = 3'h6
    } ptrp_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PWAIT = 2'b01,
        ST_RMWH  = 2'b10
    } ptrp_state_e;

    typedef struct packed {
        ptrp_op_e          op;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_W-1:0] page;
        logic [NIB-1:0]    wdata;
        logic [1:0]        bitsel;
    } ptrp_req_s;

    typedef struct packed {
        logic          valid;
        logic          re;
        logic          we;
        logic          bset;
        logic          bclr;
        logic [4:0]    addr;
        logic [NIB-1:0] wdata;
        logic [1:0]    bitsel;
    } ptrp_sfr_s;

    typedef struct packed {
        logic               we;
        logic [PROM_AW-1:0] addr;
        logic [PROM_DW-1:0] data;
    } ptrp_prog_s;

endpackage

// *** logic/ptrp_prom.sv ***
// Program word store, rewritable through the image-load port, with guarded read port.
module ptrp_prom
    import ptrp_pkg::*;
#(
    parameter int                 WORDS = PROM_WORDS,
    parameter int                 AW    = PROM_AW,
    parameter int                 DW    = PROM_DW,
    parameter logic [AW-1:0]      LIMIT = PROM_READ_LIMIT
)(
    // Clock
    input  wire logic          clk_i,
    // Image load
    input  wire logic          prog_we_i,
    input  wire logic [AW-1:0] prog_addr_i,
    input  wire logic [DW-1:0] prog_data_i,
    // Read
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [WORDS];

    always_ff @(posedge clk_i) begin
        if (prog_we_i && (prog_addr_i < AW'(WORDS))) begin
            mem[prog_addr_i] <= prog_data_i;
        end
    end

    // The reserved block reads as zero even if a stray address gets here.
    assign rd_data_o = (rd_addr_i < LIMIT) ? mem[rd_addr_i] : '0;

endmodule

// *** logic/ptrp_sram.sv ***
// User nibble SRAM with one write port and an asynchronous read.
module ptrp_sram
    import ptrp_pkg::*;
#(
    parameter int WORDS = SRAM_WORDS,
    parameter int AW    = SRAM_AW,
    parameter int DW    = NIB
)(
    // Clock
    input  wire logic          clk_i,
    // Access
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [WORDS];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[addr_i];

endmodule

// *** logic/ptrp_top.sv ***
// Table-read port: pointer, data-space decode, SRAM map and watchdog kick.
module ptrp_top
    import ptrp_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    // Core request
    input  wire logic           req_valid_i,
    input  wire ptrp_req_s      req_i,
    // Core answer
    output logic                busy_o,
    output logic                done_o,
    output logic [NIB-1:0]      rdata_o,
    // Peripheral registers
    output ptrp_sfr_s           sfr_o,
    input  wire logic [NIB-1:0] sfr_rdata_i,
    // Watchdog
    output logic                wdt_clr_o,
    // Program image load
    input  wire ptrp_prog_s     prog_i
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ptrp_state_e         state_ff;
    ptrp_state_e         nxt_state;
    logic [NIB-1:0]      ptr_lo_ff;
    logic [NIB-1:0]      ptr_mid_ff;
    logic [PTR_HI_W-1:0] ptr_hi_ff;
    logic [NIB-1:0]      nxt_lo;
    logic [NIB-1:0]      nxt_mid;
    logic [PTR_HI_W-1:0] nxt_hi;
    logic [ADDR_W-1:0]   rmw_addr_ff;
    logic [PAGE_W-1:0]   rmw_page_ff;
    logic                take;
    logic                wb_go;
    logic                wr_go;
    logic                rd_go;
    logic                bit_go;
    logic [ADDR_W-1:0]   ea;
    logic [PAGE_W-1:0]   ep;
    logic                hit_cmn;
    logic                hit_own;
    logic                hit_ext;
    logic                hit_sram;
    logic                hit_bit;
    logic                hit_data;
    logic                prom_ld;
    logic                kick;
    logic [PROM_AW-1:0]  waddr;
    logic [PROM_DW-1:0]  word;
    logic [NIB-1:0]      sram_q;
    logic [NIB-1:0]      rd_val;
    logic [NIB-1:0]      w_lo;
    logic [NIB-1:0]      w_mid;
    logic [NIB-1:0]      w_hi;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // A request is refused only while a program-word load is finishing.
    assign take  = req_valid_i && (state_ff != ST_PWAIT);
    assign wb_go = take && (req_i.op == OP_WB) && (state_ff == ST_RMWH);

    // A write-back goes to the latched address, not the one on the bus.
    assign ea = wb_go ? rmw_addr_ff : req_i.addr;
    assign ep = wb_go ? rmw_page_ff : req_i.page;

    assign hit_cmn  = (ea <= CMN_LAST);
    assign hit_own  = hit_cmn && (ea >= OWN_FIRST);
    assign hit_ext  = hit_cmn && !hit_own;
    assign hit_sram = !hit_cmn && (ep == SRAM_PAGE);
    assign hit_bit  = (ea <= BIT_LAST);
    assign hit_data = (ea == OFS_DATA_LOW) || (ea == OFS_DATA_MID) ||
                      (ea == OFS_DATA_HIGH);

    assign rd_go  = take && ((req_i.op == OP_LD_RD) || (req_i.op == OP_ALU_RD) ||
                             (req_i.op == OP_RMW_RD));
    assign wr_go  = (take && (req_i.op == OP_WR)) || wb_go;
    assign bit_go = take && ((req_i.op == OP_BSET) || (req_i.op == OP_BCLR)) &&
                    hit_bit;

    // Only the plain load is slowed down; other reads of the data registers
    // are not expected from software and get the one-cycle answer.
    assign prom_ld = take && (req_i.op == OP_LD_RD) && hit_own && hit_data;
    assign kick    = wr_go && (ea == OFS_DATA_MID) && (req_i.wdata == WDT_KICK_VAL);

    assign waddr = {ptr_hi_ff, ptr_mid_ff, ptr_lo_ff};
    assign w_lo  = word[NIB-1:0];
    assign w_mid = word[2*NIB-1:NIB];
    assign w_hi  = word[3*NIB-1:2*NIB];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    ptrp_prom #(
        .WORDS (PROM_WORDS),
        .AW    (PROM_AW),
        .DW    (PROM_DW),
        .LIMIT (PROM_READ_LIMIT)
    ) u_prom (
        .clk_i       (mclk_i),
        .prog_we_i   (prog_i.we),
        .prog_addr_i (prog_i.addr),
        .prog_data_i (prog_i.data),
        .rd_addr_i   (waddr),
        .rd_data_o   (word)
    );

    ptrp_sram #(
        .WORDS (SRAM_WORDS),
        .AW    (SRAM_AW),
        .DW    (NIB)
    ) u_sram (
        .clk_i   (mclk_i),
        .we_i    (wr_go && hit_sram),
        .addr_i  (ea[SRAM_AW-1:0]),
        .wdata_i (req_i.wdata),
        .rdata_o (sram_q)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE, ST_RMWH: begin
                if (take) begin
                    if (prom_ld) begin
                        nxt_state = ST_PWAIT;
                    end else if (req_i.op == OP_RMW_RD) begin
                        nxt_state = ST_RMWH;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_PWAIT: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Word pointer
    // ------------------------------------------------------------------
    // The pointer only moves when software writes it; there is no
    // auto-increment between the three nibble loads.
    always_comb begin
        nxt_lo  = ptr_lo_ff;
        nxt_mid = ptr_mid_ff;
        nxt_hi  = ptr_hi_ff;
        if (wr_go && hit_own) begin
            case (ea)
                OFS_PTR_LOW: begin
                    nxt_lo = req_i.wdata;
                end
                OFS_PTR_MID: begin
                    nxt_mid = req_i.wdata;
                end
                OFS_PTR_HIGH: begin
                    nxt_hi = req_i.wdata[PTR_HI_W-1:0];
                end
                default: begin
                    nxt_lo = ptr_lo_ff;
                end
            endcase
        end
        // Pulled out of the reserved block before it is ever stored.
        if ({nxt_hi, nxt_mid[NIB-1:1]} == RSV_TAG) begin
            nxt_hi[HI_CLR_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_lo_ff  <= PTR_RST;
            ptr_mid_ff <= PTR_RST;
            ptr_hi_ff  <= PTR_RST[PTR_HI_W-1:0];
        end else begin
            ptr_lo_ff  <= nxt_lo;
            ptr_mid_ff <= nxt_mid;
            ptr_hi_ff  <= nxt_hi;
        end
    end

    // ------------------------------------------------------------------
    // Read-modify-write latch
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rmw_addr_ff <= '0;
            rmw_page_ff <= '0;
        end else if (take && (req_i.op == OP_RMW_RD)) begin
            rmw_addr_ff <= req_i.addr;
            rmw_page_ff <= req_i.page;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        if (hit_ext) begin
            rd_val = sfr_rdata_i;
        end else if (hit_own) begin
            case (ea)
                OFS_PTR_LOW: begin
                    rd_val = ptr_lo_ff;
                end
                OFS_PTR_MID: begin
                    rd_val = ptr_mid_ff;
                end
                OFS_PTR_HIGH: begin
                    rd_val = {{(NIB-PTR_HI_W){1'b0}}, ptr_hi_ff};
                end
                OFS_DATA_LOW: begin
                    rd_val = w_lo;
                end
                OFS_DATA_MID: begin
                    rd_val = w_mid;
                end
                OFS_DATA_HIGH: begin
                    rd_val = w_hi;
                end
                default: begin
                    rd_val = '0;
                end
            endcase
        end else if (hit_sram) begin
            rd_val = sram_q;
        end
    end

    // ------------------------------------------------------------------
    // Core answer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_o  <= 1'b0;
            busy_o  <= 1'b0;
            rdata_o <= '0;
        end else begin
            done_o <= (take && !prom_ld) || (state_ff == ST_PWAIT);
            busy_o <= (nxt_state == ST_PWAIT);
            if (rd_go) begin
                rdata_o <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // Peripheral register side and watchdog
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_o <= '0;
        end else begin
            sfr_o.valid  <= hit_ext && (rd_go || wr_go || bit_go);
            sfr_o.re     <= hit_ext && rd_go;
            sfr_o.we     <= hit_ext && wr_go;
            sfr_o.bset   <= bit_go && (req_i.op == OP_BSET);
            sfr_o.bclr   <= bit_go && (req_i.op == OP_BCLR);
            sfr_o.addr   <= ea[4:0];
            sfr_o.wdata  <= req_i.wdata;
            sfr_o.bitsel <= req_i.bitsel;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_clr_o <= 1'b0;
        end else begin
            wdt_clr_o <= kick;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_ptr_not_rsvd: assert property (
        {ptr_hi_ff, ptr_mid_ff[NIB-1:1]} != RSV_TAG
    ) else $error("pointer left in reserved block");

    a_rsv_keep_bits: assert property (
        wr_go && (ea == OFS_PTR_HIGH) && (ptr_mid_ff[NIB-1:1] == RSV_TAG[2:0])
        |=> (ptr_hi_ff == {&$past(req_i.wdata[1:0]), $past(req_i.wdata[0])}) &&
            $stable(ptr_lo_ff) && $stable(ptr_mid_ff)
    ) else $error("reserved clear touched wrong bits");

    a_high_zero_top: assert property (
        rd_go && (ea == OFS_PTR_HIGH) |=> rdata_o[NIB-1:PTR_HI_W] == '0
    ) else $error("upper pointer bits not zero");

    a_prom_two_cyc: assert property (
        prom_ld |=> (busy_o && !done_o) ##1 (done_o && !busy_o)
    ) else $error("program word load not two cycles");

    a_other_one_cyc: assert property (
        take && !prom_ld |=> done_o && !busy_o
    ) else $error("access not one cycle");

    a_low_nibble: assert property (
        prom_ld && (ea == OFS_DATA_LOW) |-> ##2 rdata_o == $past(w_lo, 2)
    ) else $error("low data nibble wrong");

    a_mid_nibble: assert property (
        prom_ld && (ea == OFS_DATA_MID) |-> ##2 rdata_o == $past(w_mid, 2)
    ) else $error("middle data nibble wrong");

    a_high_nibble: assert property (
        prom_ld && (ea == OFS_DATA_HIGH) |-> ##2 rdata_o == $past(w_hi, 2)
    ) else $error("high data nibble wrong");

    a_wdt_kick: assert property (
        take && (req_i.op == OP_WR) && (req_i.addr == OFS_DATA_MID)
        |=> wdt_clr_o == ($past(req_i.wdata) == WDT_KICK_VAL)
    ) else $error("watchdog kick mismatch");

    a_ro_ignored: assert property (
        take && (req_i.op == OP_WR) &&
        ((req_i.addr == OFS_DATA_LOW) || (req_i.addr == OFS_DATA_HIGH))
        |=> $stable(ptr_lo_ff) && $stable(ptr_mid_ff) && $stable(ptr_hi_ff)
    ) else $error("read-only write changed pointer");

    a_bitop_range: assert property (
        sfr_o.bset || sfr_o.bclr |-> !sfr_o.addr[4]
    ) else $error("bit operation outside low range");

    a_cmn_page_free: assert property (
        take && (req_i.op == OP_WR) && (req_i.addr < OWN_FIRST) |=> sfr_o.we
    ) else $error("common access dropped");

    a_rmw_back: assert property (
        take && (req_i.op == OP_RMW_RD) && (req_i.addr < OWN_FIRST)
        ##1 !take ##1 (take && (req_i.op == OP_WB))
        |=> sfr_o.we && (sfr_o.addr == $past(req_i.addr[4:0], 3))
    ) else $error("write-back went elsewhere");

endmodule

// *** tb/ptrp_sfr_model.sv ***
// Behavioural model of the external special registers at 00H-17H.
module ptrp_sfr_model
    import ptrp_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    // Access from the port
    input  wire logic [4:0]     addr_i,
    input  wire ptrp_sfr_s      sfr_i,
    output logic      [NIB-1:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NIB-1:0] regs_ff [24];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 24; i++) begin
                regs_ff[i] <= 4'h0;
            end
        end else if (sfr_i.valid) begin
            if (sfr_i.we) begin
                regs_ff[sfr_i.addr] <= sfr_i.wdata;
            end
            if (sfr_i.bset) begin
                regs_ff[sfr_i.addr][sfr_i.bitsel] <= 1'b1;
            end
            if (sfr_i.bclr) begin
                regs_ff[sfr_i.addr][sfr_i.bitsel] <= 1'b0;
            end
        end
    end

    // Addresses outside the model read a changing pattern, never a stale value.
    assign rdata_o = (addr_i < 5'h18) ? regs_ff[addr_i] : ~addr_i[3:0];
endmodule

// *** tb/prom_table_read_port_tb.sv ***
// Self-checking bench for the table-read port.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module prom_table_read_port_tb;
    import ptrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i = 1'b0;
    logic rst_i, req_valid_i, busy_o, done_o, wdt_clr_o, kick;
    ptrp_req_s req_i;
    ptrp_prog_s prog_i;
    ptrp_sfr_s sfr_o, sfr_q;
    logic [NIB-1:0] rdata_o, sfr_rdata_i, rd;
    logic [11:0] w;
    int failures = 0;
    int n_checks = 0;
    int cyc;
    logic [9:0] pa [3] = '{10'h000, 10'h156, 10'h25F};

    always #10 mclk_i = ~mclk_i;

    ptrp_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
        .sfr_o(sfr_o), .sfr_rdata_i(sfr_rdata_i), .wdt_clr_o(wdt_clr_o),
        .prog_i(prog_i));
    ptrp_sfr_model ext (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(req_i.addr[4:0]),
        .sfr_i(sfr_o), .rdata_o(sfr_rdata_i));

    function automatic logic [11:0] img(input logic [9:0] a);
        return 12'(a * 7) ^ 12'h05A3;
    endfunction

    task automatic complete_run();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic acc(input ptrp_op_e op, input logic [5:0] a, input logic [3:0] wd,
                       input logic [3:0] pg = 4'h0, input logic [1:0] bs = 2'h0);
        int c;
        @(negedge mclk_i);
        req_i = '{op, a, pg, wd, bs};
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        kick = wdt_clr_o;
        sfr_q = sfr_o;
        c = 1;
        while (done_o !== 1'b1 && c < 8) begin
            @(negedge mclk_i);
            c++;
        end
        if (done_o !== 1'b1) begin
            failures++;
            complete_run();
        end
        cyc = c;
        rd = rdata_o;
    endtask

    task automatic chk_rd(input string nm, input logic [5:0] a, input logic [3:0] e,
                          input logic [3:0] pg = 4'h0);
        acc(OP_LD_RD, a, 4'h0, pg);
        `CHK(nm, e, rd)
    endtask

    task automatic wr_ptr(input logic [9:0] a);
        acc(OP_WR, 6'h1A, {2'b00, a[9:8]});
        acc(OP_WR, 6'h19, a[7:4]);
        acc(OP_WR, 6'h18, a[3:0]);
    endtask

    initial begin
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        prog_i = '0;
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        `CHK("busy_rst", 1'b0, busy_o)
        `CHK("wdt_rst", 1'b0, wdt_clr_o)
        `CHK("sfr_rst", '0, sfr_o)
        chk_rd("ptr_hi_rst", 6'h1A, 4'h0);
        for (int a = 0; a < PROM_WORDS; a++) begin
            @(negedge mclk_i);
            prog_i = '{1'b1, 10'(a), img(10'(a))};
        end
        @(negedge mclk_i);
        prog_i = '0;
        $display("test reset done");
        foreach (pa[i]) begin
            wr_ptr(pa[i]);
            w = img(pa[i]);
            chk_rd("data_lo", 6'h1C, w[3:0]);
            `CHK("ld_cycles", 2, cyc)
            chk_rd("data_mid", 6'h1D, w[7:4]);
            chk_rd("data_hi", 6'h1E, w[11:8]);
            acc(OP_WR, 6'h1F, 4'hA);
            `CHK("wr_cycles", 1, cyc)
        end
        $display("test prom_read done");
        acc(OP_WR, 6'h19, 4'h7);
        chk_rd("rsv_hi", 6'h1A, 4'h0);
        chk_rd("rsv_mid", 6'h19, 4'h7);
        chk_rd("rsv_lo", 6'h18, 4'hF);
        w = img(10'h07F);
        chk_rd("rsv_data", 6'h1C, w[3:0]);
        acc(OP_WR, 6'h1A, 4'hF);
        chk_rd("hi_top0", 6'h1A, 4'h3);
        acc(OP_WR, 6'h1A, 4'h2);
        chk_rd("rsv_hi_wr", 6'h1A, 4'h0);
        wr_ptr(10'h07F);
        $display("test reserved done");
        acc(OP_WR, 6'h1D, 4'h5);
        `CHK("kick", 1'b1, kick)
        acc(OP_WR, 6'h1D, 4'h4);
        `CHK("no_kick", 1'b0, kick)
        acc(OP_WR, 6'h1C, 4'h0);
        acc(OP_WR, 6'h1E, 4'h0);
        chk_rd("ro_ptr", 6'h18, 4'hF);
        chk_rd("ro_data", 6'h1E, w[11:8]);
        @(negedge mclk_i);
        req_i = '{OP_LD_RD, 6'h1C, 4'h0, 4'h0, 2'h0};
        req_valid_i = 1'b1;
        @(negedge mclk_i);
        req_i = '{OP_WR, 6'h18, 4'h0, 4'h3, 2'h0};
        `CHK("busy", 1'b1, busy_o)
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        chk_rd("refused", 6'h18, 4'hF);
        $display("test kick done");
        for (int i = 0; i < SRAM_WORDS; i++) begin
            acc(OP_WR, 6'(6'h20 + i), 4'(i) ^ 4'h5);
        end
        for (int i = 0; i < SRAM_WORDS; i++) begin
            chk_rd("sram", 6'(6'h20 + i), 4'(i) ^ 4'h5);
        end
        chk_rd("sram_pg1", 6'h25, 4'h0, 4'h1);
        acc(OP_WR, 6'h25, 4'hA, 4'h1);
        chk_rd("sram_kept", 6'h25, 4'h0);
        $display("test sram done");
        acc(OP_WR, 6'h03, 4'h9, 4'h5);
        `CHK("ext_we", {1'b1, 5'h03, 4'h9}, {sfr_q.we, sfr_q.addr, sfr_q.wdata})
        chk_rd("ext_ld", 6'h03, 4'h9, 4'h5);
        acc(OP_ALU_RD, 6'h03, 4'h0);
        `CHK("ext_alu", 4'h9, rd)
        acc(OP_WR, 6'h04, 4'h6);
        acc(OP_RMW_RD, 6'h04, 4'h0);
        `CHK("rmw_rd", 4'h6, rd)
        acc(OP_WB, 6'h00, 4'h7);
        `CHK("rmw_wb", {1'b1, 5'h04}, {sfr_q.we, sfr_q.addr})
        chk_rd("rmw_res", 6'h04, 4'h7);
        acc(OP_BSET, 6'h02, 4'h0, 4'h0, 2'h2);
        `CHK("bset", 1'b1, sfr_q.bset)
        chk_rd("bset_val", 6'h02, 4'h4);
        acc(OP_BCLR, 6'h02, 4'h0, 4'h0, 2'h2);
        chk_rd("bclr_val", 6'h02, 4'h0);
        acc(OP_BSET, 6'h12, 4'h0, 4'h0, 2'h1);
        `CHK("bset_hi", 1'b0, sfr_q.bset)
        $display("test ext done");
        complete_run();
    end
endmodule
